/* File: rtl/bmd_bus_host.sv */
// processor-side end: AHB-Lite registers drive single link cycles
`timescale 1ns/10ps
module bmd_bus_host #(
	parameter int STROBE_CYCLES = bmd_pkg::STROBE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	bmd_link_if.host link
);
	if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin : g_bad_strobe
		$error("strobe length out of range");
	end
	localparam logic [7:0] LAST_CNT = 8'(STROBE_CYCLES - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bmd_pkg::bmd_cyc_t cy_reg, cy_next;
	logic [1:0] op_reg, op_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [15:0] addr_reg, addr_next, cyc_addr_reg, cyc_addr_next;
	logic [7:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic refused_reg, refused_next, done_reg, done_next;
	logic pin_rst_reg, pin_rst_next, int_fetch_reg, int_fetch_next;
	logic pfs_n_reg, pfs_n_next, rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
	logic doe_n_reg, doe_n_next;
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_off_reg, wr_off_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic access;
	logic cmd_wr;

	always_comb begin
		cy_next = cy_reg;
		op_next = op_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		cyc_addr_next = cyc_addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		refused_next = refused_reg;
		done_next = done_reg;
		pin_rst_next = pin_rst_reg;
		int_fetch_next = int_fetch_reg;
		pfs_n_next = pfs_n_reg;
		rd_n_next = rd_n_reg;
		wr_n_next = wr_n_reg;
		doe_n_next = doe_n_reg;
		hrdata_next = hrdata_reg;
		// --------------------------------------------------------
		// bus slave: address phase capture, zero wait states
		// --------------------------------------------------------
		access = hsel_i & htrans_i[1] & hready_i;
		wr_pend_next = access & hwrite_i;
		wr_off_next = access ? haddr_i[7:0] : wr_off_reg;
		if (access & !hwrite_i) begin
			hrdata_next = 32'h0000_0000;
			unique case (haddr_i[7:0])
				bmd_pkg::REG_ADDR: hrdata_next[15:0] = addr_reg;
				bmd_pkg::REG_WDATA: hrdata_next[7:0] = wdata_reg;
				bmd_pkg::REG_CMD: hrdata_next[1:0] = op_reg;
				bmd_pkg::REG_STAT: begin
					hrdata_next[bmd_pkg::STAT_BUSY] =
						(cy_reg != bmd_pkg::BMD_CY_IDLE);
					hrdata_next[bmd_pkg::STAT_REFUSED] = refused_reg;
					hrdata_next[bmd_pkg::STAT_DONE] = done_reg;
				end
				bmd_pkg::REG_RDATA: hrdata_next[7:0] = rdata_reg;
				bmd_pkg::REG_PINS: begin
					hrdata_next[bmd_pkg::PINS_RESET] = pin_rst_reg;
					hrdata_next[bmd_pkg::PINS_INT_FETCH] = int_fetch_reg;
				end
				default: hrdata_next = 32'h0000_0000;
			endcase
		end
		cmd_wr = 1'b0;
		if (wr_pend_reg & (cy_reg == bmd_pkg::BMD_CY_IDLE)) begin
			unique case (wr_off_reg)
				bmd_pkg::REG_ADDR: addr_next = hwdata_i[15:0];
				bmd_pkg::REG_WDATA: wdata_next = hwdata_i[7:0];
				bmd_pkg::REG_CMD: cmd_wr = 1'b1;
				bmd_pkg::REG_PINS: begin
					pin_rst_next = hwdata_i[bmd_pkg::PINS_RESET];
					int_fetch_next = hwdata_i[bmd_pkg::PINS_INT_FETCH];
				end
				default: ;
			endcase
		end
		// --------------------------------------------------------
		// link cycle sequencer
		// --------------------------------------------------------
		unique case (cy_reg)
			bmd_pkg::BMD_CY_IDLE: begin
				if (cmd_wr) begin
					op_next = hwdata_i[1:0];
					done_next = 1'b0;
					refused_next = (hwdata_i[1:0] == bmd_pkg::BMD_OP_CODE_WR);
					if (hwdata_i[1:0] != bmd_pkg::BMD_OP_CODE_WR) begin
						cyc_addr_next = addr_reg;
						cy_next = bmd_pkg::BMD_CY_SETUP;
					end
				end
			end
			bmd_pkg::BMD_CY_SETUP: begin
				cnt_next = 8'h00;
				pfs_n_next = !(op_reg == bmd_pkg::BMD_OP_CODE_RD);
				rd_n_next = !(op_reg == bmd_pkg::BMD_OP_DATA_RD);
				wr_n_next = !(op_reg == bmd_pkg::BMD_OP_DATA_WR);
				doe_n_next = !(op_reg == bmd_pkg::BMD_OP_DATA_WR);
				cy_next = bmd_pkg::BMD_CY_STROBE;
			end
			bmd_pkg::BMD_CY_STROBE: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == LAST_CNT) begin
					if (op_reg != bmd_pkg::BMD_OP_DATA_WR) begin
						rdata_next = link.data;
					end
					pfs_n_next = 1'b1;
					rd_n_next = 1'b1;
					wr_n_next = 1'b1;
					cy_next = bmd_pkg::BMD_CY_HOLD;
				end
			end
			bmd_pkg::BMD_CY_HOLD: begin
				doe_n_next = 1'b1;
				done_next = 1'b1;
				cy_next = bmd_pkg::BMD_CY_IDLE;
			end
			default: cy_next = bmd_pkg::BMD_CY_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cy_reg <= bmd_pkg::BMD_CY_IDLE;
			op_reg <= bmd_pkg::BMD_OP_CODE_RD;
			cnt_reg <= 8'h00;
			addr_reg <= bmd_pkg::RESET_FETCH_ADDR;
			cyc_addr_reg <= bmd_pkg::RESET_FETCH_ADDR;
			wdata_reg <= 8'h00;
			rdata_reg <= 8'h00;
			refused_reg <= 1'b0;
			done_reg <= 1'b0;
			pin_rst_reg <= 1'b0;
			int_fetch_reg <= 1'b0;
			pfs_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			doe_n_reg <= 1'b1;
			wr_pend_reg <= 1'b0;
			wr_off_reg <= 8'h00;
			hrdata_reg <= bmd_pkg::HRDATA_RESET;
		end else if (ce_i) begin
			cy_reg <= cy_next;
			op_reg <= op_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			cyc_addr_reg <= cyc_addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			refused_reg <= refused_next;
			done_reg <= done_next;
			pin_rst_reg <= pin_rst_next;
			int_fetch_reg <= int_fetch_next;
			pfs_n_reg <= pfs_n_next;
			rd_n_reg <= rd_n_next;
			wr_n_reg <= wr_n_next;
			doe_n_reg <= doe_n_next;
			wr_pend_reg <= wr_pend_next;
			wr_off_reg <= wr_off_next;
			hrdata_reg <= hrdata_next;
		end
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign link.addr = cyc_addr_reg;
	assign link.program_fetch_strobe_n = pfs_n_reg;
	assign link.read_strobe_n = rd_n_reg;
	assign link.write_strobe_n = wr_n_reg;
	assign link.external_fetch_select_n = int_fetch_reg;
	assign link.board_reset_n = !pin_rst_reg;
	assign link.host_data = wdata_reg;
	assign link.host_data_oe_n = doe_n_reg;
endmodule : bmd_bus_host

/* File: rtl/bmd_decoder.sv */
// board memory decoder: socket, bank and io selects on the device end
`timescale 1ns/10ps
module bmd_decoder #(
	parameter int DATA_W = bmd_pkg::DATA_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	bmd_link_if.dev link,
	input wire logic map_swap_switch_i,
	input wire logic socket_type_jumper_a_i,
	input wire logic socket_type_jumper_b_i,
	input wire logic split_bank_enable_jumper_i,
	input wire logic bank_overlap_jumper_i,
	input wire logic [DATA_W-1:0] small_rdata_i,
	input wire logic [DATA_W-1:0] large_rdata_i,
	output logic [bmd_pkg::SMALL_AW-1:0] small_addr_o,
	output logic small_cs_n_o,
	output logic small_oe_n_o,
	output logic small_we_n_o,
	output logic [bmd_pkg::LARGE_AW-1:0] large_addr_o,
	output logic large_cs_n_o,
	output logic large_oe_n_o,
	output logic large_we_n_o,
	output logic [DATA_W-1:0] mem_wdata_o,
	output logic external_io_select_n_o,
	output logic monitor_led_o,
	output logic user_led_o
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DATA_W != bmd_pkg::DATA_W) begin : g_bad_width
		$error("data width must match the link");
	end

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic is_io_page(
		input logic [bmd_pkg::ADDR_W-1:0] a
	);
		is_io_page = (a[bmd_pkg::ADDR_W-1:8] == bmd_pkg::IO_PAGE);
	endfunction : is_io_page

	// true when the address lies in the half that the small socket owns
	function automatic logic small_half_hit(
		input logic [bmd_pkg::ADDR_W-1:0] a,
		input logic swapped
	);
		small_half_hit = (a[bmd_pkg::HALF_BIT] == swapped);
	endfunction : small_half_hit

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic swap_reg;
	logic swap_next;
	bmd_pkg::bmd_phase_t phase_reg;
	bmd_pkg::bmd_phase_t phase_next;
	logic monitor_led_reg;
	logic monitor_led_next;
	logic user_led_reg;
	logic user_led_next;

	// ----------------------------------------------------------------
	// combinational decode
	// ----------------------------------------------------------------
	logic io_hit;
	logic code_rd;
	logic data_rd;
	logic data_wr;
	logic merged_rd;
	logic small_half;
	logic small_ram;
	logic reloc;
	logic overlap;
	logic small_sel;
	logic large_sel;
	logic bank;
	logic rd_en;
	logic wr_en;

	always_comb begin
		io_hit = is_io_page(link.addr);
		code_rd = !link.program_fetch_strobe_n;
		data_rd = !link.read_strobe_n;
		data_wr = !link.write_strobe_n;
		// NAND of the active-low strobes: high when either strobe is low
		merged_rd = !(link.program_fetch_strobe_n & link.read_strobe_n);
		small_half = small_half_hit(link.addr, swap_reg);
		// a split jumper pair counts as ROM so nothing gets overwritten
		small_ram = socket_type_jumper_a_i & socket_type_jumper_b_i;
		reloc = split_bank_enable_jumper_i;
		overlap = reloc & bank_overlap_jumper_i;
		small_sel = 1'b0;
		large_sel = 1'b0;
		bank = bmd_pkg::CODE_BANK;
		rd_en = 1'b0;
		wr_en = 1'b0;
		if (io_hit) begin
			small_sel = 1'b0;
			large_sel = 1'b0;
		end else if (!reloc) begin
			rd_en = merged_rd;
			wr_en = data_wr & !small_half;
			if (small_half) begin
				wr_en = data_wr & small_ram;
			end
			small_sel = small_half & (merged_rd | wr_en);
			large_sel = !small_half & (merged_rd | data_wr);
		end else if (phase_reg == bmd_pkg::BMD_PH_MON) begin
			// monitor loads user code through data space into code bank
			rd_en = code_rd | data_rd;
			wr_en = data_wr;
			if (code_rd & small_half) begin
				small_sel = 1'b1;
			end else begin
				large_sel = code_rd | data_rd | data_wr;
			end
			if (small_sel & data_wr & !small_ram) begin
				wr_en = 1'b0;
			end
		end else begin
			// user phase: monitor socket is gone from the map
			small_sel = 1'b0;
			rd_en = overlap ? merged_rd : (code_rd | data_rd);
			wr_en = data_wr;
			large_sel = rd_en | wr_en;
			if ((data_rd | data_wr) & !overlap) begin
				bank = bmd_pkg::DATA_BANK;
			end
		end
	end

	// ----------------------------------------------------------------
	// memory and io strobes
	// ----------------------------------------------------------------
	assign small_addr_o = link.addr[bmd_pkg::SMALL_AW-1:0];
	assign small_cs_n_o = !small_sel;
	assign small_oe_n_o = !(small_sel & rd_en);
	assign small_we_n_o = !(small_sel & wr_en & small_ram);
	// full 64K plus bank bit only in relocating mode
	assign large_addr_o = reloc ? {bank, link.addr} :
		{2'b00, link.addr[bmd_pkg::SMALL_AW-1:0]};
	assign large_cs_n_o = !large_sel;
	assign large_oe_n_o = !(large_sel & rd_en);
	assign large_we_n_o = !(large_sel & wr_en);
	assign mem_wdata_o = link.data;
	assign external_io_select_n_o = !(io_hit &
		(code_rd | data_rd | data_wr));

	// ----------------------------------------------------------------
	// read data back onto the shared wire
	// ----------------------------------------------------------------
	assign link.dev_data = small_sel ? small_rdata_i : large_rdata_i;
	assign link.dev_data_oe_n = !((small_sel | large_sel) & rd_en);

	// ----------------------------------------------------------------
	// map state: switch tracking and monitor phase
	// ----------------------------------------------------------------
	always_comb begin
		swap_next = swap_reg;
		phase_next = phase_reg;
		if (!link.board_reset_n) begin
			// switch may be moved only while the button is down
			swap_next = !map_swap_switch_i;
			phase_next = bmd_pkg::BMD_PH_MON;
		end else begin
			unique case (phase_reg)
				bmd_pkg::BMD_PH_MON: begin
					if (reloc & data_wr &
						(link.addr == bmd_pkg::USER_ENTRY_ADDR)) begin
						phase_next = bmd_pkg::BMD_PH_USER;
					end
				end
				bmd_pkg::BMD_PH_USER: begin
					if (!reloc) begin
						phase_next = bmd_pkg::BMD_PH_MON;
					end
				end
				default: begin
					phase_next = bmd_pkg::BMD_PH_MON;
				end
			endcase
		end
		monitor_led_next = !swap_next & (phase_next == bmd_pkg::BMD_PH_MON);
		user_led_next = swap_next | (phase_next == bmd_pkg::BMD_PH_USER);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			swap_reg <= 1'b0;
			phase_reg <= bmd_pkg::BMD_PH_MON;
			monitor_led_reg <= 1'b1;
			user_led_reg <= 1'b0;
		end else if (ce_i) begin
			swap_reg <= swap_next;
			phase_reg <= phase_next;
			monitor_led_reg <= monitor_led_next;
			user_led_reg <= user_led_next;
		end
	end

	assign monitor_led_o = monitor_led_reg;
	assign user_led_o = user_led_reg;
endmodule : bmd_decoder

/* File: rtl/bmd_link_if.sv */
// processor external memory bus between host end and decoder
`timescale 1ns/10ps
interface bmd_link_if;
	logic [bmd_pkg::ADDR_W-1:0] addr;
	logic program_fetch_strobe_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic external_fetch_select_n;
	logic board_reset_n;
	logic [bmd_pkg::DATA_W-1:0] host_data;
	logic host_data_oe_n;
	logic [bmd_pkg::DATA_W-1:0] dev_data;
	logic dev_data_oe_n;
	logic [bmd_pkg::DATA_W-1:0] data;

	// ----------------------------------------------------------------
	// shared data wire, pulled high when nobody drives
	// ----------------------------------------------------------------
	assign data = !host_data_oe_n ? host_data :
		!dev_data_oe_n ? dev_data : bmd_pkg::BUS_IDLE_DATA;

	modport host (
		output addr,
		output program_fetch_strobe_n,
		output read_strobe_n,
		output write_strobe_n,
		output external_fetch_select_n,
		output board_reset_n,
		output host_data,
		output host_data_oe_n,
		input data
	);

	modport dev (
		input addr,
		input program_fetch_strobe_n,
		input read_strobe_n,
		input write_strobe_n,
		input external_fetch_select_n,
		input board_reset_n,
		output dev_data,
		output dev_data_oe_n,
		input data
	);
endinterface : bmd_link_if

/* File: rtl/bmd_pkg.sv */
// shared constants and types for the board memory decoder and its bus end
package bmd_pkg;
	// ----------------------------------------------------------------
	// link widths and map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int SMALL_AW = 15;
	localparam int LARGE_AW = 17;
	localparam int HALF_BIT = 15;
	localparam logic [7:0] IO_PAGE = 8'hfe;
	localparam logic [15:0] USER_ENTRY_ADDR = 16'hfeff;
	localparam logic [15:0] RESET_FETCH_ADDR = 16'h0000;
	localparam logic CODE_BANK = 1'h0;
	localparam logic DATA_BANK = 1'h1;
	localparam logic [7:0] BUS_IDLE_DATA = 8'hff;

	// ----------------------------------------------------------------
	// timing of one link cycle
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int STROBE_NS = 24;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// host register map, byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_ADDR = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_PINS = 8'h14;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_DONE = 2;
	localparam int PINS_RESET = 0;
	localparam int PINS_INT_FETCH = 1;
	localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// commands and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BMD_OP_CODE_WR = 2'h0,
		BMD_OP_CODE_RD = 2'h1,
		BMD_OP_DATA_RD = 2'h2,
		BMD_OP_DATA_WR = 2'h3
	} bmd_op_t;

	typedef enum logic [1:0] {
		BMD_PH_MON = 2'b01,
		BMD_PH_USER = 2'b10
	} bmd_phase_t;

	typedef enum logic [3:0] {
		BMD_CY_IDLE = 4'b0001,
		BMD_CY_SETUP = 4'b0010,
		BMD_CY_STROBE = 4'b0100,
		BMD_CY_HOLD = 4'b1000
	} bmd_cyc_t;
endpackage : bmd_pkg

/* File: tb/bmd_link_properties.sv */
// concurrent checks on the memory link and the decoder selects
`timescale 1ns/10ps
module bmd_link_properties (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] addr,
	input wire logic program_fetch_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic small_cs_n_o,
	input wire logic small_we_n_o,
	input wire logic small_oe_n_o,
	input wire logic large_oe_n_o,
	input wire logic large_we_n_o,
	input wire logic large_cs_n_o,
	input wire logic [16:0] large_addr_o,
	input wire logic external_io_select_n_o,
	input wire logic socket_type_jumper_a_i,
	input wire logic socket_type_jumper_b_i,
	input wire logic split_bank_enable_jumper_i,
	input wire logic bank_overlap_jumper_i
);
	logic rd_stb;
	logic any_stb;
	logic io_pg;
	assign rd_stb = !program_fetch_strobe_n || !read_strobe_n;
	assign any_stb = rd_stb || !write_strobe_n;
	assign io_pg = addr[15:8] == 8'hfe;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// --------
	// strobe shape
	// --------
	// three cycles low matches the default strobe length of the host end
	sequence s_rd_low;
		!read_strobe_n [*3];
	endsequence
	sequence s_rd_end;
		s_rd_low ##1 read_strobe_n;
	endsequence

	a_strobe_len: assert property ($fell(read_strobe_n) |-> s_rd_end)
		else $error("read strobe length wrong");
	a_no_code_write: assert property (!write_strobe_n |->
		program_fetch_strobe_n && read_strobe_n)
		else $error("write overlaps a read strobe");

	// --------
	// selects
	// --------
	a_one_socket: assert property (!(!small_cs_n_o && !large_cs_n_o))
		else $error("both sockets selected");
	a_io_no_mem: assert property (any_stb && io_pg |->
		!external_io_select_n_o && small_cs_n_o && large_cs_n_o)
		else $error("io page access selected memory");
	a_io_in_page: assert property (!external_io_select_n_o |->
		io_pg && any_stb)
		else $error("io select outside io page");
	a_small_we_ram: assert property (!small_we_n_o |->
		socket_type_jumper_a_i && socket_type_jumper_b_i && !write_strobe_n)
		else $error("small socket written in rom setting");
	a_small_oe_read: assert property (!small_oe_n_o |->
		rd_stb && !small_cs_n_o)
		else $error("small socket output enabled without a read");
	a_large_oe_read: assert property (!large_oe_n_o |->
		rd_stb && !large_cs_n_o)
		else $error("large socket output enabled without a read");
	a_large_we_wr: assert property (!large_we_n_o |->
		!write_strobe_n && !large_cs_n_o)
		else $error("large socket written without a write strobe");
	a_overlap_read: assert property (!split_bank_enable_jumper_i &&
		rd_stb && !io_pg |-> small_cs_n_o != large_cs_n_o)
		else $error("overlapped read selects no single socket");
	a_code_bank: assert property (split_bank_enable_jumper_i &&
		!large_cs_n_o && !program_fetch_strobe_n |-> !large_addr_o[16])
		else $error("code fetch left bank zero");
	a_ovl_bank: assert property (split_bank_enable_jumper_i &&
		bank_overlap_jumper_i && !large_cs_n_o && !read_strobe_n
		|-> !large_addr_o[16])
		else $error("overlapped data read left bank zero");
endmodule : bmd_link_properties

/* File: tb/board_memory_decoder_tb.sv */
// self-checking bench: host end and decoder joined over the link
`timescale 1ns/10ps
module board_memory_decoder_tb;
	logic clk_i;
	logic rst_n_i;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hready;
	logic sw, ja, jb, jsplit, jovl;
	logic small_cs_n, small_we_n, large_cs_n, io_n, mon_led, user_led;
	logic small_oe_n, large_oe_n, large_we_n;
	logic [16:0] large_addr;
	logic stb;
	logic [5:0] seen;
	logic seen_clr;
	logic [31:0] r;
	int num_errors;
	int n_checks;

	bmd_link_if bmd_link_if_i ();
	bmd_bus_host bmd_bus_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(), .link(bmd_link_if_i));
	bmd_decoder bmd_decoder_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.link(bmd_link_if_i), .map_swap_switch_i(sw),
		.socket_type_jumper_a_i(ja), .socket_type_jumper_b_i(jb),
		.split_bank_enable_jumper_i(jsplit), .bank_overlap_jumper_i(jovl),
		.small_rdata_i(8'h5a), .large_rdata_i(8'ha5), .small_addr_o(),
		.small_cs_n_o(small_cs_n), .small_oe_n_o(small_oe_n),
		.small_we_n_o(small_we_n), .large_addr_o(large_addr),
		.large_cs_n_o(large_cs_n), .large_oe_n_o(large_oe_n),
		.large_we_n_o(large_we_n), .mem_wdata_o(),
		.external_io_select_n_o(io_n),
		.monitor_led_o(mon_led), .user_led_o(user_led));
	bmd_link_properties bmd_link_properties_i (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .addr(bmd_link_if_i.addr),
		.program_fetch_strobe_n(bmd_link_if_i.program_fetch_strobe_n),
		.read_strobe_n(bmd_link_if_i.read_strobe_n),
		.write_strobe_n(bmd_link_if_i.write_strobe_n),
		.small_cs_n_o(small_cs_n), .small_we_n_o(small_we_n),
		.small_oe_n_o(small_oe_n), .large_oe_n_o(large_oe_n),
		.large_we_n_o(large_we_n),
		.large_cs_n_o(large_cs_n), .large_addr_o(large_addr),
		.external_io_select_n_o(io_n), .socket_type_jumper_a_i(ja),
		.socket_type_jumper_b_i(jb), .split_bank_enable_jumper_i(jsplit),
		.bank_overlap_jumper_i(jovl));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// --------
	// select capture
	// --------
	// flags: strobe, io, small, large, small write, large bank one
	assign stb = !bmd_link_if_i.program_fetch_strobe_n ||
		!bmd_link_if_i.read_strobe_n || !bmd_link_if_i.write_strobe_n;
	always @(posedge clk_i) begin
		if (seen_clr) begin
			seen <= '0;
		end else if (stb) begin
			seen <= seen | {1'b1, !io_n, !small_cs_n, !large_cs_n, !small_we_n,
				!large_cs_n && large_addr[16]};
		end
	end

	// --------
	// helpers
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// ops: 0 code write, 1 code read, 2 data read, 3 data write
	task automatic lop(input logic [1:0] op, input logic [15:0] a);
		int k;
		ahb(1'b1, bmd_pkg::REG_ADDR, {16'h0, a}, r);
		ahb(1'b1, bmd_pkg::REG_WDATA, 32'h3c, r);
		// capture clears itself while the link is idle: one driver only
		seen_clr <= 1'b1;
		ahb(1'b1, bmd_pkg::REG_CMD, {30'h0, op}, r);
		seen_clr <= 1'b0;
		k = 0;
		do begin
			ahb(1'b0, bmd_pkg::REG_STAT, 32'h0, r);
			k++;
		end while (r[bmd_pkg::STAT_BUSY] !== 1'b0 && k < 40);
		// a link cycle that never ends counts as a mismatch
		if (r[bmd_pkg::STAT_BUSY] !== 1'b0) begin
			num_errors++;
		end
		ahb(1'b0, bmd_pkg::REG_RDATA, 32'h0, r);
	endtask : lop

	task automatic go(input logic [1:0] op, input logic [15:0] a,
		input logic [5:0] exp);
		lop(op, a);
		chk({26'h0, seen}, {26'h0, exp});
	endtask : go

	task automatic board_reset(input logic pos);
		ahb(1'b1, bmd_pkg::REG_PINS, 32'h1, r);
		sw <= pos;
		repeat (2) @(posedge clk_i);
		ahb(1'b1, bmd_pkg::REG_PINS, 32'h0, r);
	endtask : board_reset

	// --------
	// scenarios
	// --------
	task automatic t_mon();
		go(2'h1, 16'h0100, 6'b101000);
		chk(r, 32'h5a);
		go(2'h2, 16'h0100, 6'b101000);
		chk(r, 32'h5a);
		go(2'h1, 16'h7fff, 6'b101000);
		go(2'h2, 16'h8000, 6'b100100);
		chk(r, 32'ha5);
		go(2'h1, 16'hffff, 6'b100100);
		go(2'h2, 16'hfe10, 6'b110000);
	endtask : t_mon

	task automatic t_jump();
		lop(2'h3, 16'h0100);
		chk({29'h0, seen[5], seen[2], seen[1]}, 32'h4);
		ja <= 1'b1;
		lop(2'h3, 16'h0100);
		chk({29'h0, seen[5], seen[2], seen[1]}, 32'h4);
		jb <= 1'b1;
		lop(2'h3, 16'h0100);
		chk({29'h0, seen[5], seen[2], seen[1]}, 32'h5);
		go(2'h3, 16'h8000, 6'b100100);
		go(2'h0, 16'h0100, 6'b000000);
		ahb(1'b0, bmd_pkg::REG_STAT, 32'h0, r);
		chk({31'h0, r[bmd_pkg::STAT_REFUSED]}, 32'h1);
	endtask : t_jump

	task automatic t_run();
		// switch passes through monitor first while the button is held
		board_reset(1'b1);
		sw <= 1'b0;
		board_reset(1'b0);
		chk({30'h0, mon_led, user_led}, 32'h1);
		go(2'h1, 16'h0000, 6'b100100);
		chk(r, 32'ha5);
		go(2'h2, 16'h8000, 6'b101000);
		board_reset(1'b1);
		chk({30'h0, mon_led, user_led}, 32'h2);
		go(2'h1, 16'h0000, 6'b101000);
	endtask : t_run

	task automatic t_reloc();
		jsplit <= 1'b1;
		go(2'h1, 16'h0000, 6'b101000);
		go(2'h2, 16'h0000, 6'b100100);
		go(2'h3, 16'hfeff, 6'b110000);
		chk({30'h0, mon_led, user_led}, 32'h1);
		go(2'h1, 16'h0000, 6'b100100);
		go(2'h2, 16'h0000, 6'b100101);
		go(2'h1, 16'h7000, 6'b100100);
		jovl <= 1'b1;
		go(2'h2, 16'h0000, 6'b100100);
		board_reset(1'b1);
		go(2'h1, 16'h0000, 6'b101000);
	endtask : t_reloc

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		num_errors = 0;
		n_checks = 0;
		rst_n_i = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sw = 1'b1;
		ja = 1'b0;
		jb = 1'b0;
		jsplit = 1'b0;
		jovl = 1'b0;
		seen_clr = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		chk({31'h0, bmd_link_if_i.external_fetch_select_n}, 32'h0);
		ahb(1'b1, bmd_pkg::REG_PINS, 32'h2, r);
		// the pin flop moves on the edge that ends the write
		@(posedge clk_i);
		chk({31'h0, bmd_link_if_i.external_fetch_select_n}, 32'h1);
		ahb(1'b1, bmd_pkg::REG_PINS, 32'h0, r);
		t_mon();
		t_jump();
		t_run();
		t_reloc();
		ahb(1'b1, 8'h20, 32'h1234, r);
		ahb(1'b0, 8'h20, 32'h0, r);
		chk(r, 32'h0);
		end_of_test();
	end

	// about 23 link cycles of some 16 clocks each; over thirty times that margin
	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end
endmodule : board_memory_decoder_tb
